// ==== inc/nfh_regs.svh ====
// Constants for the NAND flash host sequencer
// Behaviour
// (R1) Device floats bus when deselected or disabled
// (R2) Command latched on strobe rise with flag
// (R3) Address latched on strobe rise with flag
// (R4) Device ignores deselect while busy
// (R5) Output strobe fall advances column by one
// (R6) Device drives read byte while strobe low
// (R7) Bytes taken on input strobe rising edge
// (R8) Lockout low holds high voltage in reset
// (R9) Ready/busy low during array operations
// (R10) Ready/busy open drain, host pulls up
// (R11) Second select enables second die
// (R12) Address sent low byte first, 2+3 cycles
// (R13) Unused address bits driven to zero
// (R14) Device ignores surplus address cycles
// (R15) Sequential readout at 25ns per byte
// (R16) Program page 2K+64 bytes, about 200us
// (R17) Erase block 128K+4K bytes, about 1.5ms
// (R18) Device sequences program and erase itself
// (R19) Writes accepted only with select low
// (R20) Read and program use five address cycles
// (R21) Erase uses three row cycles only
// (R22) Setup command, addresses, execute command
// (R23) Device drivers off during command/address phases
`ifndef NFH_REGS_SVH
`define NFH_REGS_SVH
`define NFH_CLK_NS 100
`define NFH_SERIAL_NS 25
`define NFH_PHASE_CYC 1
`define NFH_PROG_US 200
`define NFH_ERASE_US 1500
`define NFH_PROG_CYC ((`NFH_PROG_US * 1000) / `NFH_CLK_NS)
`define NFH_ERASE_CYC ((`NFH_ERASE_US * 1000) / `NFH_CLK_NS)
`define NFH_COL_BYTES 2
`define NFH_ROW_BYTES 3
`define NFH_PAGE_BYTES 2112
`define NFH_OP_READ 2'h0
`define NFH_OP_PROG 2'h1
`define NFH_OP_ERASE 2'h2
`define NFH_CMD_READ1 8'h00
`define NFH_CMD_READ2 8'h30
`define NFH_CMD_PROG1 8'h80
`define NFH_CMD_PROG2 8'h10
`define NFH_CMD_ERASE1 8'h60
`define NFH_CMD_ERASE2 8'hD0
`define NFH_COL_HI_MASK 8'h0F
`define NFH_ROW_HI_MASK 8'h07
`endif

// ==== inc/nfh_pkg.sv ====
// Types for the NAND flash host sequencer
package nfh_pkg;
  typedef enum logic [3:0] {
    NFH_IDLE = 4'h0,
    NFH_CMD1 = 4'h1,
    NFH_ADDR = 4'h2,
    NFH_WDATA = 4'h3,
    NFH_CMD2 = 4'h4,
    NFH_BUSY = 4'h5,
    NFH_RDATA = 4'h6,
    NFH_RWAIT = 4'h7,
    NFH_DONE = 4'h8
  } nfh_state_t;
  typedef logic [1:0] nfh_op_t;
endpackage

// ==== rtl/nfh_host.sv ====
// Host sequencer driving a NAND flash over its strobes and shared bus
`timescale 1ns/1ps
`default_nettype none
`include "nfh_regs.svh"
module nfh_host #(
  parameter int PROG_CYC = `NFH_PROG_CYC,
  parameter int ERASE_CYC = `NFH_ERASE_CYC,
  parameter int PAGE_BYTES = `NFH_PAGE_BYTES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  output logic req_ready,
  input wire nfh_pkg::nfh_op_t req_op,
  input wire logic req_die,
  input wire logic [11:0] req_col,
  input wire logic [18:0] req_row,
  input wire logic [15:0] req_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic done_pulse_ff,
  output logic timeout_ff,
  output logic die_one_select_n,
  output logic die_two_select_n,
  output logic cmd_phase,
  output logic addr_phase,
  output logic input_strobe_n,
  output logic output_strobe_n,
  output logic lockout_n,
  input wire logic [7:0] shared_bus_in,
  output logic [7:0] shared_bus_out,
  output logic shared_bus_oe,
  input wire logic die_one_ready_busy_n,
  input wire logic die_two_ready_busy_n
);
  import nfh_pkg::*;
  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;

  nfh_state_t state_ff;
  logic phase_ff;
  logic [2:0] abyte_ff;
  logic [39:0] addr_ff;
  logic [15:0] cnt_ff;
  logic [31:0] wait_ff;
  nfh_op_t op_ff;
  logic die_ff;
  logic [7:0] bus_ff;
  logic oe_ff, cle_ff, ale_ff, we_n_ff, re_n_ff, sel_ff;
  logic [1:0] rb_ff;

  // Two-entry read buffer so a receiver stall within one read loses no byte
  logic [7:0] buf_mem [0:1];
  logic wp_ff, rp_ff;
  logic [1:0] lvl_ff;
  wire buf_full = (lvl_ff == 2'h2);
  wire buf_push;
  wire buf_pop = rd_valid && rd_ready;
  assign rd_valid = (lvl_ff != 2'h0);
  assign rd_data = buf_mem[rp_ff];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      lvl_ff <= 2'h0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else begin
      if (buf_push) begin
        buf_mem[wp_ff] <= shared_bus_in; // R6
        wp_ff <= ~wp_ff;
      end
      if (buf_pop) begin
        rp_ff <= ~rp_ff;
      end
      lvl_ff <= lvl_ff + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // R12 R13: column bits then row bits, unused high bits zero
  wire [39:0] addr_img = {5'h00, req_row[18:16], req_row[15:0], 4'h0, req_col};
  wire [2:0] first_abyte = (req_op == `NFH_OP_ERASE) ? 3'h2 : 3'h0; // R21 R20
  wire ready_line = die_ff ? rb_ff[1] : rb_ff[0]; // R10
  wire [31:0] busy_len = (op_ff == `NFH_OP_PROG) ? PROG_CYC :
                         (op_ff == `NFH_OP_ERASE) ? ERASE_CYC : PROG_CYC;

  assign req_ready = (state_ff == NFH_IDLE);
  assign wr_ready = (state_ff == NFH_WDATA) && !phase_ff;
  // Each read byte costs at least three clocks, far slower than the 25ns minimum
  assign buf_push = (state_ff == NFH_RDATA) && phase_ff; // R15

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_ff <= 2'h0;
    end else begin
      rb_ff <= {die_two_ready_busy_n, die_one_ready_busy_n}; // R9
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= NFH_IDLE;
      phase_ff <= 1'b0;
      abyte_ff <= 3'h0;
      addr_ff <= 40'h0;
      cnt_ff <= 16'h0;
      wait_ff <= 32'h0;
      op_ff <= `NFH_OP_READ;
      die_ff <= 1'b0;
      bus_ff <= 8'h00;
      oe_ff <= 1'b0;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      we_n_ff <= 1'b1;
      re_n_ff <= 1'b1;
      sel_ff <= 1'b0;
      done_pulse_ff <= 1'b0;
      timeout_ff <= 1'b0;
    end else begin
      done_pulse_ff <= 1'b0;
      case (state_ff)
        NFH_IDLE: begin
          oe_ff <= 1'b0;
          sel_ff <= 1'b0;
          if (req_valid) begin
            op_ff <= req_op;
            die_ff <= req_die; // R11
            addr_ff <= addr_img;
            abyte_ff <= first_abyte;
            cnt_ff <= (req_len > PAGE_BYTES[15:0]) ? PAGE_BYTES[15:0] : req_len; // R16
            timeout_ff <= 1'b0;
            sel_ff <= 1'b1; // R19
            state_ff <= NFH_CMD1;
            phase_ff <= 1'b0;
          end
        end
        NFH_CMD1, NFH_CMD2: begin
          // Low half drives strobe low, high half releases it to latch
          if (!phase_ff) begin
            cle_ff <= 1'b1; // R2
            ale_ff <= 1'b0;
            oe_ff <= 1'b1; // R23
            we_n_ff <= 1'b0;
            if (state_ff == NFH_CMD1) begin
              bus_ff <= (op_ff == `NFH_OP_PROG) ? `NFH_CMD_PROG1 :
                        (op_ff == `NFH_OP_ERASE) ? `NFH_CMD_ERASE1 : `NFH_CMD_READ1; // R22
            end else begin
              bus_ff <= (op_ff == `NFH_OP_PROG) ? `NFH_CMD_PROG2 :
                        (op_ff == `NFH_OP_ERASE) ? `NFH_CMD_ERASE2 : `NFH_CMD_READ2; // R22
            end
            phase_ff <= 1'b1;
          end else begin
            we_n_ff <= 1'b1; // R7
            phase_ff <= 1'b0;
            if (state_ff == NFH_CMD1) begin
              state_ff <= NFH_ADDR;
            end else begin
              wait_ff <= 32'h0;
              state_ff <= NFH_BUSY;
            end
          end
        end
        NFH_ADDR: begin
          if (!phase_ff) begin
            cle_ff <= 1'b0;
            ale_ff <= 1'b1; // R3
            we_n_ff <= 1'b0;
            bus_ff <= addr_ff[abyte_ff*8 +: 8]; // R12
            phase_ff <= 1'b1;
          end else begin
            we_n_ff <= 1'b1; // R7
            phase_ff <= 1'b0;
            if (abyte_ff == 3'h4) begin
              // Flag stays up past the last strobe rise; the next state drops it
              state_ff <= (op_ff == `NFH_OP_PROG && cnt_ff != 16'h0) ? NFH_WDATA : NFH_CMD2;
            end else begin
              abyte_ff <= abyte_ff + 3'h1;
            end
          end
        end
        NFH_WDATA: begin
          if (!phase_ff) begin
            ale_ff <= 1'b0; // R3
            if (wr_valid) begin
              bus_ff <= wr_data;
              we_n_ff <= 1'b0;
              phase_ff <= 1'b1;
            end
          end else begin
            we_n_ff <= 1'b1; // R7
            phase_ff <= 1'b0;
            cnt_ff <= cnt_ff - 16'h1;
            if (cnt_ff == 16'h1) begin
              state_ff <= NFH_CMD2;
            end
          end
        end
        NFH_BUSY: begin
          // Device owns the sequence; host only waits for ready, chip stays selected
          wait_ff <= wait_ff + 32'h1; // R4 R18
          // Flag and bus were held one clock past the strobe rise for hold time
          cle_ff <= 1'b0; // R7
          oe_ff <= 1'b0; // R7
          if (wait_ff > `NFH_PHASE_CYC && ready_line) begin
            if (op_ff == `NFH_OP_READ && cnt_ff != 16'h0) begin
              state_ff <= NFH_RDATA;
              phase_ff <= 1'b0;
            end else begin
              state_ff <= NFH_DONE;
            end
          end else if (wait_ff > (busy_len << 2) + 32'h100) begin
            timeout_ff <= 1'b1; // R17
            state_ff <= NFH_DONE;
          end
        end
        NFH_RDATA: begin
          if (!phase_ff) begin
            re_n_ff <= 1'b0; // R5
            phase_ff <= 1'b1;
          end else begin
            re_n_ff <= 1'b1;
            phase_ff <= 1'b0;
            cnt_ff <= cnt_ff - 16'h1;
            state_ff <= (cnt_ff == 16'h1) ? NFH_DONE : NFH_RWAIT;
          end
        end
        NFH_RWAIT: begin
          // Hold the strobe high until the buffer has room
          if (!buf_full && !(lvl_ff == 2'h1 && !buf_pop)) begin
            state_ff <= NFH_RDATA;
          end else if (lvl_ff == 2'h1 && !buf_pop) begin
            state_ff <= NFH_RDATA;
          end
        end
        NFH_DONE: begin
          sel_ff <= 1'b0;
          done_pulse_ff <= 1'b1;
          state_ff <= NFH_IDLE;
        end
        default: begin
          state_ff <= NFH_IDLE;
        end
      endcase
    end
  end

  assign die_one_select_n = !(sel_ff && !die_ff);
  assign die_two_select_n = !(sel_ff && die_ff);
  assign cmd_phase = cle_ff;
  assign addr_phase = ale_ff;
  assign input_strobe_n = we_n_ff;
  assign output_strobe_n = re_n_ff;
  assign shared_bus_out = bus_ff;
  assign shared_bus_oe = oe_ff && re_n_ff; // R1
  assign lockout_n = rst_n; // R8
endmodule
`default_nettype wire

// ==== testbench/nfh_host_properties.sv ====
// Pin protocol checker for the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
module nfh_host_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic die_one_select_n,
  input wire logic die_two_select_n,
  input wire logic cmd_phase,
  input wire logic addr_phase,
  input wire logic input_strobe_n,
  input wire logic output_strobe_n,
  input wire logic [7:0] shared_bus_out,
  input wire logic shared_bus_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] n_ff;
  logic [7:0] c_ff;
  wire logic w = !input_strobe_n;
  wire logic r = !output_strobe_n;
  wire logic [7:0] b = shared_bus_out;
  // Address bytes since the last command byte
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      n_ff <= 3'h0;
      c_ff <= 8'h00;
    end else if (w && cmd_phase) begin
      n_ff <= 3'h0;
      c_ff <= b;
    end else if (w && addr_phase) begin
      n_ff <= n_ff + 3'h1;
    end
  end
  sequence s_cycle;
    w ##1 !w && $stable(b) && shared_bus_oe;
  endsequence
  a_write_cycle: assert property ($fell(input_strobe_n) |-> s_cycle)
    else $error("bad write cycle");
  a_one_select: assert property (w || r |-> die_one_select_n ^ die_two_select_n)
    else $error("select not unique");
  a_phase_excl: assert property (cmd_phase |-> !addr_phase)
    else $error("both phases high");
  a_read_quiet: assert property (r |-> !shared_bus_oe && !cmd_phase && !addr_phase && !w)
    else $error("host drives during read");
  a_col_hi_zero: assert property (w && addr_phase && n_ff == 3'h1 && c_ff != 8'h60
    |-> b[7:4] == 4'h0) else $error("column high bits set");
  a_row_hi_zero: assert property (w && addr_phase && n_ff == (c_ff == 8'h60 ? 3'h2 : 3'h4)
    |-> b[7:3] == 5'h00) else $error("row high bits set");
  a_five_addr: assert property (w && cmd_phase && (b == 8'h30 || b == 8'h10)
    |-> n_ff == 3'h5 && c_ff == (b == 8'h30 ? 8'h00 : 8'h80)) else $error("bad setup");
  a_three_row: assert property (w && cmd_phase && b == 8'hD0
    |-> n_ff == 3'h3 && c_ff == 8'h60) else $error("bad erase setup");
endmodule
bind nfh_host nfh_host_properties u_props (.*);
`default_nettype wire

// ==== testbench/nfh_flash_model.sv ====
// Behavioural flash die answering the host strobes
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model #(
  parameter int BUSY_NS = 2000
) (
  input wire logic select_n,
  input wire logic cmd_phase,
  input wire logic addr_phase,
  input wire logic input_strobe_n,
  input wire logic output_strobe_n,
  input wire logic lockout_n,
  input wire logic [7:0] shared_bus_in,
  output logic [7:0] dout,
  output logic doe,
  output logic pull_low
);
  wire logic [7:0] b = shared_bus_in;
  // Page register and array are one store here, row is not decoded
  logic [7:0] mem [0:4095];
  logic [7:0] adr [0:4];
  logic [11:0] col = 12'h000;
  int acnt = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    pull_low = 1'b0;
    dout = 8'h00;
  end
  assign doe = !select_n && !output_strobe_n && !cmd_phase && !addr_phase;
  always @(posedge input_strobe_n) begin
    if (!select_n && cmd_phase) begin
      if (b == 8'h00 || b == 8'h80 || b == 8'h60) acnt = 0;
      if (b == 8'hD0 && lockout_n) foreach (mem[i]) mem[i] = 8'hFF;
      // Busy ends on its own clock, whether the die stays selected or not
      if (b == 8'h30 || b == 8'h10 || b == 8'hD0) begin
        pull_low = 1'b1;
        pull_low <= #(BUSY_NS) 1'b0;
      end
    end else if (!select_n && addr_phase) begin
      if (acnt < 5) adr[acnt] = b;
      acnt++;
      col = {adr[1][3:0], adr[0]};
    end else if (!select_n && lockout_n) begin
      mem[col] = b;
      col++;
    end
  end
  always @(negedge output_strobe_n) begin
    if (!select_n) begin
      dout = mem[col];
      col++;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/nfh_host_tb_top.sv ====
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
`include "nfh_regs.svh"
module nfh_host_tb_top;
  import nfh_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
  logic req_die = 1'b0;
  nfh_op_t req_op = 2'h0;
  logic [11:0] req_col = 12'h803;
  logic [18:0] req_row = 19'h4A5C3;
  logic [15:0] req_len = 16'h0004;
  logic [7:0] wr_data = 8'h00;
  logic req_ready, wr_ready, rd_valid, done_pulse_ff, timeout_ff, lockout_n, d1_oe, d2_oe;
  logic die_one_select_n, die_two_select_n, cmd_phase, addr_phase, d1_low, d2_low;
  logic input_strobe_n, output_strobe_n, shared_bus_oe;
  logic [7:0] rd_data, shared_bus_out, d1_out, d2_out;
  // Released bus toggles so a stale byte cannot pass for data
  wire logic [7:0] shared_bus_in = shared_bus_oe ? shared_bus_out : d1_oe ? d1_out
    : d2_oe ? d2_out : {4{ref_clk, ~ref_clk}};
  wire logic die_one_ready_busy_n = !d1_low;
  wire logic die_two_ready_busy_n = !d2_low;
  int failures = 0, check_count = 0, done_seen = 0, base = 0;
  always #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (done_pulse_ff === 1'b1) done_seen++;
  nfh_host #(.PROG_CYC(10), .ERASE_CYC(10)) DUT (.*);
  nfh_flash_model u_die1 (.*, .select_n(die_one_select_n), .dout(d1_out), .doe(d1_oe),
    .pull_low(d1_low));
  nfh_flash_model u_die2 (.*, .select_n(die_two_select_n), .dout(d2_out), .doe(d2_oe),
    .pull_low(d2_low));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic give_up(input string what);
    failures++;
    $display("Error %s expected activity seen none", what);
    report_and_stop();
  endtask
  task automatic send_req(input nfh_op_t op, input logic die);
    int n;
    base = done_seen;
    req_valid = 1'b1;
    req_op = op;
    req_die = die;
    for (n = 0; n < 50 && !req_ready; n++) @(negedge ref_clk);
    if (n == 50) give_up("req_ready");
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  task automatic wait_done(input string what);
    int n;
    for (n = 0; n < 900 && done_seen == base; n++) @(negedge ref_clk);
    if (n == 900) give_up(what);
    chk(what, 8'h00, {7'h00, timeout_ff});
    $display("Test %s finished", what);
  endtask
  task automatic t_program();
    int n;
    send_req(`NFH_OP_PROG, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr_valid = 1'b1;
      wr_data = 8'h3C + 8'(i);
      for (n = 0; n < 300 && !wr_ready; n++) @(negedge ref_clk);
      if (n == 300) give_up("wr_ready");
      @(negedge ref_clk);
    end
    wr_valid = 1'b0;
    wait_done("program");
  endtask
  task automatic t_read();
    int n;
    send_req(`NFH_OP_READ, 1'b0);
    for (n = 0; n < 300 && !rd_valid; n++) @(negedge ref_clk);
    if (n == 300) give_up("rd_valid");
    // Receiver stalls so the buffer fills and the sequencer must pause
    repeat (20) @(negedge ref_clk);
    rd_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      for (n = 0; n < 50 && !rd_valid; n++) @(negedge ref_clk);
      if (n == 50) give_up("rd_valid");
      chk("read byte", 8'h3C + 8'(i), rd_data);
      @(negedge ref_clk);
    end
    rd_ready = 1'b0;
    wait_done("read");
  endtask
  task automatic t_erase();
    int n;
    send_req(`NFH_OP_ERASE, 1'b1);
    for (n = 0; n < 100 && !d2_low; n++) @(negedge ref_clk);
    chk("die two busy", 8'h01, {7'h00, d2_low});
    chk("die one idle", 8'h00, {7'h00, d1_low});
    wait_done("erase");
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    chk("lockout in reset", 8'h00, {7'h00, lockout_n});
    @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("lockout", 8'h01, {7'h00, lockout_n});
    t_program();
    t_read();
    t_erase();
    t_read();
    report_and_stop();
  end
endmodule
`default_nettype wire
